// File: design/cmc_pkg.sv
// Overview of operation
// - SYSREF comes from pins when the source select bit is 0, else from register.
// - With register source selected, the level bit holds internal SYSREF low or high.
// - SYNCB input is inverted when the polarity bit is 1.
// - Per-channel 4-bit digital gain, 1 dB per code, 0 to 11 dB, before decimation.
// - Gain register exists separately on the channel A and channel B digital pages.
// - Low-rate enable registers live on the converter page, code FFh with mode cleared.
// - Offset-correction block uses the external estimate when its select bit is 1.
package cmc_pkg;

  // Page selection: 24-bit page code plus mode bit
  localparam logic [23:0] CMC_PAGE_MASTER = 24'h00_0000;
  localparam logic CMC_MODE_MASTER = 1'b0;
  localparam logic [23:0] CMC_PAGE_CONV = 24'h00_00ff;
  localparam logic CMC_MODE_CONV = 1'b0;
  localparam logic [23:0] CMC_PAGE_DIG_A = 24'h61_0000;
  localparam logic [23:0] CMC_PAGE_DIG_B = 24'h61_0100;
  localparam logic [23:0] CMC_PAGE_OFS_A = 24'h61_0000;
  localparam logic CMC_MODE_DIG = 1'b1;

  // Register offsets
  localparam logic [7:0] CMC_OFS_OFFSET_ESTIMATE_SOURCE = 8'h34;
  localparam logic [7:0] CMC_OFS_LOW_RATE_ENABLE_ONE = 8'h3f;
  localparam logic [7:0] CMC_OFS_LOW_RATE_ENABLE_TWO = 8'h42;
  localparam logic [7:0] CMC_OFS_SOFT_SYSREF_CONTROL = 8'h57;
  localparam logic [7:0] CMC_OFS_SYNC_POLARITY_CONTROL = 8'h58;
  localparam logic [7:0] CMC_OFS_DIGITAL_GAIN_CONTROL = 8'ha6;

  // Field positions
  localparam int CMC_BIT_EXT_EST = 0;
  localparam int CMC_BIT_LOW_RATE_A = 2;
  localparam int CMC_BIT_LOW_RATE_B = 4;
  localparam int CMC_BIT_SYSREF_SEL = 3;
  localparam int CMC_BIT_SYSREF_LEVEL = 4;
  localparam int CMC_BIT_SYNC_INV = 5;
  localparam int CMC_GAIN_LSB = 0;
  localparam int CMC_GAIN_W = 4;

  // Reset values
  localparam logic CMC_RST_BIT = 1'b0;
  localparam logic [3:0] CMC_RST_GAIN = 4'h0;
  localparam logic [7:0] CMC_RST_BYTE = 8'h00;

  // Datapath
  localparam int CMC_DATA_W = 14;
  localparam int CMC_CHANNELS = 2;
  localparam int CMC_FRAC_W = 11;
  localparam logic [3:0] CMC_GAIN_MAX_CODE = 4'hb;
  localparam logic [12:0] CMC_GAIN_UNITY = 13'h0800;
  // Gain factors in Q2.11, one per dB step from 0 dB to 11 dB
  localparam logic [11:0][12:0] CMC_GAIN_TABLE = {
    13'h1c63, 13'h194c, 13'h168c, 13'h1418, 13'h11e9, 13'h0ff6,
    13'h0e3a, 13'h0cae, 13'h0b4d, 13'h0a12, 13'h08fa, 13'h0800};

  typedef struct packed {
    logic sysref_level;
    logic sysref_sel;
    logic sync_inv;
    logic low_rate_a;
    logic low_rate_b;
    logic ext_est;
    logic [1:0][3:0] gain;
    logic [7:0] rd_data;
    logic [1:0][13:0] data_out;
  } cmc_state_s;

endpackage : cmc_pkg

// File: design/cmc_misc_config_regs.sv
`timescale 1ns/1ps
module cmc_misc_config_regs (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [23:0] reg_page,
  input wire logic reg_page_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Timing signals
  input wire logic sysref_pin,
  output logic sysref_int,
  input wire logic sync_in,
  output logic sync_int,
  // Configuration to the analog and offset blocks
  output logic low_rate_enable_a,
  output logic low_rate_enable_b,
  output logic external_offset_estimate_select,
  output logic [cmc_pkg::CMC_CHANNELS-1:0][3:0] pre_decimation_gain,
  // Converter data, channel 0 is A
  input wire logic [cmc_pkg::CMC_CHANNELS-1:0][cmc_pkg::CMC_DATA_W-1:0] conv_data_in,
  output logic [cmc_pkg::CMC_CHANNELS-1:0][cmc_pkg::CMC_DATA_W-1:0] conv_data_out
);
  import cmc_pkg::*;

  cmc_state_s st_q;
  cmc_state_s st_d;
  logic on_master;
  logic on_conv;
  logic on_dig_a;
  logic on_dig_b;
  logic on_ofs_a;

  // Page decode
  assign on_master = (reg_page == CMC_PAGE_MASTER) && (reg_page_mode == CMC_MODE_MASTER);
  assign on_conv = (reg_page == CMC_PAGE_CONV) && (reg_page_mode == CMC_MODE_CONV);
  assign on_dig_a = (reg_page == CMC_PAGE_DIG_A) && (reg_page_mode == CMC_MODE_DIG);
  assign on_dig_b = (reg_page == CMC_PAGE_DIG_B) && (reg_page_mode == CMC_MODE_DIG);
  assign on_ofs_a = (reg_page == CMC_PAGE_OFS_A) && (reg_page_mode == CMC_MODE_DIG);

  // Scale one sample; codes above eleven pass at unity since they are undefined
  function automatic logic [CMC_DATA_W-1:0] apply_gain(input logic [CMC_DATA_W-1:0] smp,
                                                       input logic [3:0] code);
    logic [12:0] fac;
    logic signed [27:0] prod;
    logic signed [16:0] scaled;
    fac = (code <= CMC_GAIN_MAX_CODE) ? CMC_GAIN_TABLE[code] : CMC_GAIN_UNITY;
    prod = $signed(smp) * $signed({1'b0, fac});
    scaled = prod[27:11];
    // Saturate rather than wrap, a wrapped peak would look like a full-scale spur
    if (scaled > 17'sd8191) begin
      apply_gain = 14'h1fff;
    end else if (scaled < -17'sd8192) begin
      apply_gain = 14'h2000;
    end else begin
      apply_gain = scaled[13:0];
    end
  endfunction : apply_gain

  // Next state: register writes, read capture and the gain datapath
  always_comb begin
    st_d = st_q;
    if (reg_wr_en) begin
      if (on_master && reg_addr == CMC_OFS_SOFT_SYSREF_CONTROL) begin
        st_d.sysref_sel = reg_wdata[CMC_BIT_SYSREF_SEL];
        st_d.sysref_level = reg_wdata[CMC_BIT_SYSREF_LEVEL];
      end
      if (on_master && reg_addr == CMC_OFS_SYNC_POLARITY_CONTROL) begin
        st_d.sync_inv = reg_wdata[CMC_BIT_SYNC_INV];
      end
      if (on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_ONE) begin
        st_d.low_rate_a = reg_wdata[CMC_BIT_LOW_RATE_A];
      end
      if (on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_TWO) begin
        st_d.low_rate_b = reg_wdata[CMC_BIT_LOW_RATE_B];
      end
      if (on_dig_a && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL) begin
        st_d.gain[0] = reg_wdata[CMC_GAIN_LSB +: CMC_GAIN_W];
      end
      if (on_dig_b && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL) begin
        st_d.gain[1] = reg_wdata[CMC_GAIN_LSB +: CMC_GAIN_W];
      end
      if (on_ofs_a && reg_addr == CMC_OFS_OFFSET_ESTIMATE_SOURCE) begin
        st_d.ext_est = reg_wdata[CMC_BIT_EXT_EST];
      end
    end
    // Reads return only the live field; reserved bits and unmapped addresses read zero
    if (reg_rd_en) begin
      st_d.rd_data = CMC_RST_BYTE;
      if (on_master && reg_addr == CMC_OFS_SOFT_SYSREF_CONTROL) begin
        st_d.rd_data[CMC_BIT_SYSREF_SEL] = st_q.sysref_sel;
        st_d.rd_data[CMC_BIT_SYSREF_LEVEL] = st_q.sysref_level;
      end else if (on_master && reg_addr == CMC_OFS_SYNC_POLARITY_CONTROL) begin
        st_d.rd_data[CMC_BIT_SYNC_INV] = st_q.sync_inv;
      end else if (on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_ONE) begin
        st_d.rd_data[CMC_BIT_LOW_RATE_A] = st_q.low_rate_a;
      end else if (on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_TWO) begin
        st_d.rd_data[CMC_BIT_LOW_RATE_B] = st_q.low_rate_b;
      end else if (on_dig_a && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL) begin
        st_d.rd_data[CMC_GAIN_LSB +: CMC_GAIN_W] = st_q.gain[0];
      end else if (on_dig_b && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL) begin
        st_d.rd_data[CMC_GAIN_LSB +: CMC_GAIN_W] = st_q.gain[1];
      end else if (on_ofs_a && reg_addr == CMC_OFS_OFFSET_ESTIMATE_SOURCE) begin
        st_d.rd_data[CMC_BIT_EXT_EST] = st_q.ext_est;
      end
    end
    // One register stage of gain per channel, using the gain in force now
    for (int ch = 0; ch < CMC_CHANNELS; ch++) begin
      st_d.data_out[ch] = apply_gain(conv_data_in[ch], st_q.gain[ch]);
    end
  end

  // State register; clock enable low freezes everything, but reset still clears it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // SYSREF source mux and SYNCB polarity are glue, no added latency
  assign sysref_int = st_q.sysref_sel ? st_q.sysref_level : sysref_pin;
  assign sync_int = sync_in ^ st_q.sync_inv;
  assign low_rate_enable_a = st_q.low_rate_a;
  assign low_rate_enable_b = st_q.low_rate_b;
  assign external_offset_estimate_select = st_q.ext_est;
  assign pre_decimation_gain = st_q.gain;
  assign reg_rdata = st_q.rd_data;
  assign conv_data_out = st_q.data_out;

  // Checks; a single clock domain, so one default clocking and reset serve them all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Pin path whenever the register source is not selected
  sysref_pin_path_a: assert property (!st_q.sysref_sel |-> sysref_int == sysref_pin)
    else $error("sysref not following pin");

  // Selecting the register source drives the written level from the next cycle
  sysref_soft_level_a: assert property (
    !$past(reset) && $past(ce) && $past(reg_wr_en) && $past(on_master)
    && $past(reg_addr) == CMC_OFS_SOFT_SYSREF_CONTROL
    && $past(reg_wdata[CMC_BIT_SYSREF_SEL])
    |-> sysref_int == $past(reg_wdata[CMC_BIT_SYSREF_LEVEL]))
    else $error("soft sysref level wrong");

  // Polarity write applies next cycle; judged against the written bit, not the register
  sync_invert_a: assert property (
    !$past(reset) && $past(ce) && $past(reg_wr_en) && $past(on_master)
    && $past(reg_addr) == CMC_OFS_SYNC_POLARITY_CONTROL
    |-> sync_int == (sync_in ^ $past(reg_wdata[CMC_BIT_SYNC_INV])))
    else $error("sync polarity wrong");

  // Uninverted setting passes the sync input straight through
  sync_follow_a: assert property (!st_q.sync_inv |-> sync_int == sync_in)
    else $error("sync not following input");

  // Code zero is 0 dB, so samples leave one stage later unchanged
  gain_unity_a: assert property (
    ce && !$past(reset) && $past(ce) && $past(st_q.gain[0]) == 4'h0
    |-> conv_data_out[0] == $past(conv_data_in[0]))
    else $error("0 dB gain altered data");

  // Top code on the most negative sample must clip; a wrap would flip its sign
  gain_clip_a: assert property (
    !$past(reset) && $past(ce) && $past(st_q.gain[0]) == CMC_GAIN_MAX_CODE
    && $past(conv_data_in[0]) == 14'h2000
    |-> conv_data_out[0] == 14'h2000)
    else $error("full-scale sample not clipped");

  // Each channel's gain sits on its own page and leaves the other alone
  gain_page_a_a: assert property (
    reg_wr_en && ce && on_dig_a && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL
    |=> pre_decimation_gain[0] == $past(reg_wdata[CMC_GAIN_LSB +: CMC_GAIN_W])
    && $stable(pre_decimation_gain[1]))
    else $error("channel A gain write wrong");
  gain_page_b_a: assert property (
    reg_wr_en && ce && on_dig_b && reg_addr == CMC_OFS_DIGITAL_GAIN_CONTROL
    |=> pre_decimation_gain[1] == $past(reg_wdata[CMC_GAIN_LSB +: CMC_GAIN_W])
    && $stable(pre_decimation_gain[0]))
    else $error("channel B gain write wrong");

  // Low-rate enables load only from the converter page
  low_rate_page_a: assert property (
    reg_wr_en && ce && !on_conv |=> $stable(low_rate_enable_a) && $stable(low_rate_enable_b))
    else $error("low-rate enable changed off its page");
  low_rate_one_a: assert property (
    reg_wr_en && ce && on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_ONE
    |=> low_rate_enable_a == $past(reg_wdata[CMC_BIT_LOW_RATE_A]))
    else $error("first low-rate enable write wrong");
  low_rate_two_a: assert property (
    reg_wr_en && ce && on_conv && reg_addr == CMC_OFS_LOW_RATE_ENABLE_TWO
    |=> low_rate_enable_b == $past(reg_wdata[CMC_BIT_LOW_RATE_B]))
    else $error("second low-rate enable write wrong");

  // External estimate select follows its bit on the offset page
  ext_est_follow_a: assert property (
    reg_wr_en && ce && on_ofs_a && reg_addr == CMC_OFS_OFFSET_ESTIMATE_SOURCE
    |=> external_offset_estimate_select == $past(reg_wdata[CMC_BIT_EXT_EST]))
    else $error("external estimate select wrong");

  // Reserved positions of the soft SYSREF register read back as zero whatever the host wrote there
  read_reserved_a: assert property (
    !$past(reset) && $past(ce) && $past(reg_rd_en) && $past(on_master)
    && $past(reg_addr) == CMC_OFS_SOFT_SYSREF_CONTROL
    |-> (reg_rdata & 8'he7) == CMC_RST_BYTE)
    else $error("reserved bits read nonzero");

  // Clock enable low holds every register, read data and the sample pipe included
  freeze_hold_a: assert property (!ce |=> $stable(st_q))
    else $error("state moved while frozen");

  // Main scenarios worth seeing
  soft_sysref_high_c: cover property (st_q.sysref_sel && sysref_int);
  gain_max_b_c: cover property (pre_decimation_gain[1] == CMC_GAIN_MAX_CODE);
  low_rate_both_c: cover property (low_rate_enable_a && low_rate_enable_b);
  sync_inverted_c: cover property (st_q.sync_inv && sync_in);
  frozen_write_c: cover property (!ce && reg_wr_en);

endmodule : cmc_misc_config_regs

// File: sim/cmc_misc_config_regs_bench.sv
`timescale 1ns/1ps
module cmc_misc_config_regs_bench;
  import cmc_pkg::*;
  logic core_clk = 0, reset = 1, ce = 1, reg_wr_en = 0, reg_rd_en = 0, reg_page_mode = 0;
  logic [23:0] reg_page = '0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic sysref_pin = 0, sysref_int, sync_in = 0, sync_int, lre_a, lre_b, ext_sel;
  logic [1:0][3:0] gain;
  logic [1:0][13:0] din = '0, dout, held;
  int bad_count = 0, tests_run = 0, cyc = 0;
  logic [31:0] seed = 32'h4c45_09d9;
  // Map: page, mode, offset, writable bits, model contents
  logic [23:0] pg [7] = '{CMC_PAGE_MASTER, CMC_PAGE_MASTER, CMC_PAGE_CONV, CMC_PAGE_CONV,
    CMC_PAGE_DIG_A, CMC_PAGE_DIG_B, CMC_PAGE_OFS_A};
  logic md [7] = '{0, 0, 0, 0, 1, 1, 1};
  logic [7:0] ofs [7] = '{8'h57, 8'h58, 8'h3f, 8'h42, 8'ha6, 8'ha6, 8'h34};
  logic [7:0] msk [7] = '{8'h18, 8'h20, 8'h04, 8'h10, 8'h0f, 8'h0f, 8'h01};
  logic [7:0] mdl [7] = '{default: 8'h00};
  int fac [12] = '{2048, 2298, 2578, 2893, 3246, 3642, 4086, 4585, 5144, 5772, 6476, 7267};

  always #4 core_clk = ~core_clk;
  // Hang guard, a few times the roughly four hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      conclude();
    end
  end

  cmc_misc_config_regs uut (.core_clk(core_clk), .reset(reset), .ce(ce), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_page(reg_page), .reg_page_mode(reg_page_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sysref_pin(sysref_pin), .sysref_int(sysref_int),
    .sync_in(sync_in), .sync_int(sync_int), .low_rate_enable_a(lre_a), .low_rate_enable_b(lre_b),
    .external_offset_estimate_select(ext_sel), .pre_decimation_gain(gain),
    .conv_data_in(din), .conv_data_out(dout));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Reference gain stage: scale, floor shift, clamp to 14 bits
  function automatic logic [13:0] gained(logic signed [13:0] x, int g);
    int p;
    p = (int'(x) * fac[g]) >>> 11;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[13:0];
  endfunction : gained

  task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register read data against the model byte
  task automatic chk_read(string what, logic [7:0] exp);
    tests_run++;
    if (reg_rdata !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, reg_rdata);
    end
  endtask : chk_read

  // Gained samples against the reference gain stage
  task automatic chk_data(string what, logic [13:0] exp, logic [13:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_data

  // Strobe stays high across back-to-back transfers; stop lowers it
  task automatic bus(logic [23:0] p, logic m, logic [7:0] a, logic wr, logic [7:0] d);
    reg_page = p;
    reg_page_mode = m;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    @(posedge core_clk);
    #1;
  endtask : bus

  task automatic stop();
    reg_wr_en = 0;
    reg_rd_en = 0;
    @(posedge core_clk);
    #1;
  endtask : stop

  task automatic check_outs();
    chk("sysref_int", mdl[0][3] ? mdl[0][4] : sysref_pin, sysref_int);
    chk("sync_int", sync_in ^ mdl[1][5], sync_int);
    chk("low_rate_a", mdl[2][2], lre_a);
    chk("low_rate_b", mdl[3][4], lre_b);
    chk("gain_a", mdl[4][3:0], gain[0]);
    chk("gain_b", mdl[5][3:0], gain[1]);
    chk("ext_est", mdl[6][0], ext_sel);
  endtask : check_outs

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    reset = 0;
    // Everything reads back zero out of reset
    for (int i = 0; i < 7; i++) begin
      bus(pg[i], md[i], ofs[i], 0, 8'h00);
      chk_read("reset_read", mdl[i]);
    end
    check_outs();
    // Random rounds: back-to-back writes, then reads with pins moving
    for (int r = 0; r < 16; r++) begin
      for (int i = 0; i < 7; i++) begin
        mdl[i] = 8'(rnd()) & msk[i];
        if (msk[i] == 8'h0f) mdl[i] = 8'(mdl[i] % 8'd12);
        if (i == 3) mdl[3] = {3'h0, mdl[2][2], 4'h0};
        if (i == 0) bus(pg[0], md[0], ofs[0], 1, mdl[0] & 8'h08);
        bus(pg[i], md[i], ofs[i], 1, mdl[i]);
      end
      sysref_pin = ^rnd();
      sync_in = ^rnd();
      for (int i = 0; i < 7; i++) begin
        bus(pg[i], md[i], ofs[i], 0, 8'h00);
        chk_read("read", mdl[i]);
      end
      stop();
      check_outs();
    end
    // Unmapped offset and wrong mode bit are both ignored
    bus(CMC_PAGE_MASTER, 0, 8'h59, 1, 8'hff);
    bus(pg[5], 0, ofs[5], 1, {5'h00, ~mdl[5][2:0]});
    bus(CMC_PAGE_MASTER, 0, 8'h59, 0, 8'h00);
    chk_read("unmapped", 8'h00);
    bus(pg[5], md[5], ofs[5], 0, 8'h00);
    chk_read("mode_bit", mdl[5]);
    stop();
    // Gain codes 0 to 11, channels set apart, full-scale first
    for (int g = 0; g < 12; g++) begin
      bus(pg[4], 1, ofs[4], 1, 8'(g));
      bus(pg[5], 1, ofs[5], 1, 8'(11 - g));
      stop();
      for (int k = 0; k < 6; k++) begin
        din = (k == 0) ? {14'h1fff, 14'h2000} : 28'(rnd());
        @(posedge core_clk);
        #1;
        chk_data("data_a", gained(din[0], g), dout[0]);
        chk_data("data_b", gained(din[1], 11 - g), dout[1]);
      end
    end
    // Clock enable low: writes, reads and the sample pipe all hold
    held = {gained(din[1], 0), gained(din[0], 11)};
    ce = 0;
    bus(pg[4], 1, ofs[4], 1, 8'h05);
    din = 28'(rnd());
    bus(pg[0], 0, ofs[0], 1, ~mdl[0] & 8'h18);
    bus(pg[4], 1, ofs[4], 0, 8'h00);
    stop();
    chk_data("frozen_a", held[0], dout[0]);
    chk_data("frozen_b", held[1], dout[1]);
    chk_read("frozen_read", mdl[5]);
    mdl[4] = 8'h0b;
    mdl[5] = 8'h00;
    check_outs();
    ce = 1;
    // Polarity back to the uninverted setting the host should keep
    mdl[1] = 8'h00;
    bus(pg[1], md[1], ofs[1], 1, mdl[1]);
    bus(pg[1], md[1], ofs[1], 0, 8'h00);
    chk_read("sync_pol", mdl[1]);
    stop();
    check_outs();
    conclude();
  end
endmodule : cmc_misc_config_regs_bench
